// File: inc/otpc_pkg.sv
// Shared constants and types for the one-time PROM option loader.
package otpc_pkg;

    // Array geometry as seen from the programming socket.
    localparam int           ADDR_W       = 15;
    localparam int           DATA_W       = 8;
    localparam int           ROM_WORDS    = 32768;
    localparam int           PIN_W        = 26;
    localparam logic [7:0]   ERASED_BYTE  = 8'hFF;

    // Option area at the bottom of the programmer address space.
    localparam logic [2:0]   OPT_FIRST    = 3'h0;
    localparam logic [2:0]   OPT_LAST     = 3'h6;
    localparam int           OPT_COUNT    = 7;

    // Field positions inside option bytes 0, 1 and 2.
    localparam int           OPT0_DUAL_BIT = 4;
    localparam int           OPT0_RSTO_BIT = 3;
    localparam int           OPT0_POR_BIT  = 2;
    localparam int           OPT1_PU_LSB   = 4;
    localparam int           OPT1_PU_MSB   = 7;
    localparam int           OPT2_PU_LSB   = 2;
    localparam int           OPT2_PU_MSB   = 7;

    // Bit that selects the single-chip ROM window in a CPU address.
    localparam int           CPU_ROM_BIT   = 15;

    // APB register byte offsets.
    localparam int           APB_AW        = 12;
    localparam logic [11:0]  OFS_STATUS    = 12'h000;
    localparam logic [11:0]  OFS_OPT_LO    = 12'h004;
    localparam logic [11:0]  OFS_OPT_HI    = 12'h008;
    localparam logic [11:0]  OFS_CTRL      = 12'h00C;
    localparam logic [11:0]  OFS_ROM_ADDR  = 12'h010;
    localparam logic [11:0]  OFS_ROM_DATA  = 12'h014;

    // Status and control register layout.
    localparam int           STS_DONE_BIT  = 0;
    localparam int           STS_DUAL_BIT  = 1;
    localparam int           STS_RSTO_BIT  = 2;
    localparam int           STS_POR_BIT   = 3;
    localparam int           STS_P1_LSB    = 4;
    localparam int           STS_P3_LSB    = 8;
    localparam int           CTRL_LOCK_BIT = 0;

    // Decoded option settings; pull-up selects are high to attach.
    typedef struct packed {
        logic       dual_clk;
        logic       rst_out;
        logic       por;
        logic [3:0] port1_pullup_sel;
        logic [5:0] port3_pullup_sel;
    } otpc_opt_t;

    // Programming socket inputs, grouped for synchronisation.
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  data;
        logic        ce_n;
        logic        oe_n;
        logic        pgm_n;
    } otpc_pins_t;

    // One request to the single-port array.
    typedef struct packed {
        logic        en;
        logic        we;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } otpc_mem_req_t;

    // Phases of the core and of the bus slave.
    typedef enum logic [1:0] {LD_READ, LD_CAPTURE, RUN} otpc_phase_t;
    typedef enum logic [1:0] {B_IDLE, B_MEM, B_DONE} otpc_bus_t;

endpackage

// File: core/otpc_sync.sv
// Two-stage synchroniser for the programming socket pins.
`timescale 1ns/10ps
module otpc_sync
#(
    parameter int WIDTH = 26
)
(
    input  wire logic             pclk,     // System clock.
    input  wire logic             presetn,  // Asynchronous reset, low.
    input  wire logic [WIDTH-1:0] async_in, // Pin levels.
    output logic      [WIDTH-1:0] sync_out  // Levels after two flops.
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;  // First stage, read only by second.
        logic [WIDTH-1:0] sync;  // Second stage, safe to use.
    } otpc_sync_t;

    otpc_sync_t s_q;
    otpc_sync_t s_d;

    // Next state: shift the pin levels through the two stages.
    always_comb
    begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    // Reset to all ones so strobes read as idle after reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;
endmodule // otpc_sync

// File: core/otpc_mem.sv
// One-time PROM array with registered read and clear-only writes.
`timescale 1ns/10ps
module otpc_mem
    import otpc_pkg::*;
(
    input  wire logic                    pclk,    // System clock.
    input  wire logic                    presetn, // Asynchronous reset.
    input  wire otpc_pkg::otpc_mem_req_t req,     // Array request.
    output logic       [7:0]             rdata    // Read data, next cycle.
);
    typedef struct packed {
        logic        past_we;    // A write happened last cycle.
        logic [14:0] last_addr;  // Address of that write.
        logic [7:0]  last_old;   // Byte before that write.
        logic [7:0]  last_wdata; // Data offered by that write.
        logic [7:0]  rd;         // Registered read data.
    } otpc_mem_t;

    logic [7:0] mem [0:ROM_WORDS-1]; // The array itself.
    otpc_mem_t  s_q;
    otpc_mem_t  s_d;

    // An unprogrammed part holds all ones in every byte.
    initial
    begin
        for (int i = 0; i < ROM_WORDS; i++)
        begin
            mem[i] = ERASED_BYTE;
        end
    end

    // Array update: a write can only pull bits from one to zero.
    // A plain clocked process, since the erased fill above also
    // writes the array and the array must not lose that content.
    always @(posedge pclk)
    begin
        if (req.en && req.we)
        begin
            mem[req.addr] <= mem[req.addr] & req.wdata;
        end
    end

    // Next state of the read register and the write history.
    always_comb
    begin
        s_d            = s_q;
        s_d.past_we    = req.en && req.we;
        if (req.en)
        begin
            s_d.rd         = mem[req.addr];
            s_d.last_addr  = req.addr;
            s_d.last_old   = mem[req.addr];
            s_d.last_wdata = req.wdata;
        end
    end

    // Clocked state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rd;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_bits_only_clear: assert property (
        s_q.past_we |-> ((mem[s_q.last_addr] & ~s_q.last_old) == 8'h00))
        else $error("Write set a bit that was already zero.");
    chk_one_unless_zero: assert property (
        s_q.past_we |->
            (mem[s_q.last_addr] == (s_q.last_old & s_q.last_wdata)))
        else $error("Bit differs from old value and written data.");
endmodule // otpc_mem

// File: core/otpc_top.sv
// Option loader and programming port for the one-time PROM.
// Operation
// - Programmer address maps to CPU address with bit15.
// - No signature readout mode; never relied on.
// - Option0 bit4 selects dual or single clock.
// - Option0 bit3 enables reset pin output.
// - Option0 bit2 enables power-on reset.
// - Option1 bits7-4: port1 pull-ups, low attaches.
// - Option2 bits7-2: port3 pull-ups, low attaches.
// - Vacant bits read one unless zero programmed.
// - Erased is one; programming only clears bits.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
module otpc_top
    import otpc_pkg::*;
(
    input  wire logic        pclk,             // System clock.
    input  wire logic        presetn,          // Async reset, low.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB access phase.
    input  wire logic        pwrite,           // APB write.
    input  wire logic [11:0] paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error.
    input  wire logic [14:0] prog_addr,        // Socket address pins.
    input  wire logic [7:0]  prog_din,         // Socket data, in.
    output logic      [7:0]  prog_dout,        // Socket data, out.
    output logic             prog_doe,         // Socket data enable.
    input  wire logic        prog_ce_n,        // Socket chip enable.
    input  wire logic        prog_oe_n,        // Socket output enable.
    input  wire logic        prog_pgm_n,       // Socket program strobe.
    output logic             dual_clk_en,      // Dual-clock system.
    output logic             rst_out_en,       // Reset pin drives out.
    output logic             por_en,           // Power-on reset on.
    output logic      [3:0]  port1_pullup_sel, // Port 1 pins 4..7.
    output logic      [5:0]  port3_pullup_sel, // Port 3 pins 2..7.
    output logic             opt_valid         // Options are loaded.
);
    // Whole state of the core in one record.
    typedef struct packed {
        otpc_phase_t       phase;     // Load or run.
        logic [2:0]        ld_idx;    // Option byte being loaded.
        logic [6:0][7:0]   opt_bytes; // Raw option bytes.
        otpc_opt_t         opt;       // Decoded settings.
        logic              done;      // Load finished.
        logic              pgm_n_d;   // Last synced program strobe.
        logic              wr_pend;   // Program pulse waiting.
        logic [14:0]       wr_addr;   // Its address.
        logic [7:0]        wr_data;   // Its data.
        logic              prd_iss;   // Socket read issued last cycle.
        logic              bus_iss;   // Bus read issued last cycle.
        logic [7:0]        pdout;     // Socket read data.
        logic              pdoe;      // Socket drive enable.
        logic              lock;      // Programming writes refused.
        logic [15:0]       rom_addr;  // CPU address for bus reads.
        otpc_bus_t         bus;       // Bus slave phase.
        logic [31:0]       prdata;    // Bus read data.
        logic              pready;    // Bus ready.
        logic              pslverr;   // Bus error.
    } otpc_core_t;

    otpc_core_t    s_q;      // Registered state.
    otpc_core_t    s_d;      // Next state.
    otpc_pins_t    pins_raw; // Pins as they arrive.
    otpc_pins_t    pins;     // Pins after synchronisation.
    otpc_mem_req_t req;      // Array request this cycle.
    logic [7:0]    mem_rd;   // Array read data.
    logic          bus_req;  // Unanswered APB access phase.
    logic          sock_rd;  // Socket asks for a read.

    assign pins_raw = '{addr: prog_addr, data: prog_din,
                        ce_n: prog_ce_n, oe_n: prog_oe_n,
                        pgm_n: prog_pgm_n};

    // The programmer holds address and data for microseconds around
    // each pulse, so per-bit synchronising cannot tear a word.
    otpc_sync #(.WIDTH(PIN_W)) u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    otpc_mem u_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req),
        .rdata   (mem_rd)
    );

    assign bus_req = psel && penable && !s_q.pready;
    assign sock_rd = !pins.ce_n && !pins.oe_n;

    // All next-state logic: loader, socket port, array arbiter, APB.
    always_comb
    begin
        s_d        = s_q;
        req        = '0;
        s_d.prd_iss = 1'b0;
        s_d.bus_iss = 1'b0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.pgm_n_d = pins.pgm_n;

        // A program pulse is the falling edge of the strobe with chip
        // enable low; option bytes take the same path as code.
        if (!pins.pgm_n && s_q.pgm_n_d && !pins.ce_n)
        begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = pins.addr;
            s_d.wr_data = pins.data;
        end

        // Socket reads always return array contents; a raised A9 is
        // just an address bit, as no signature mode exists.
        s_d.pdoe = (s_q.phase == RUN) && sock_rd;
        if (s_q.prd_iss)
        begin
            s_d.pdout = mem_rd;
        end

        unique case (s_q.phase)
            // Read the option area once after reset.
            LD_READ:
            begin
                req.en   = 1'b1;
                req.addr = {12'h000, s_q.ld_idx};
                s_d.phase = LD_CAPTURE;
            end
            LD_CAPTURE:
            begin
                s_d.opt_bytes[s_q.ld_idx] = mem_rd;
                if (s_q.ld_idx == OPT_LAST)
                begin
                    s_d.phase = RUN;
                    s_d.done  = 1'b1;
                end
                else
                begin
                    s_d.ld_idx = s_q.ld_idx + 3'h1;
                    s_d.phase  = LD_READ;
                end
            end
            // Run: pending write first, then socket read, then bus.
            RUN:
            begin
                if (s_q.wr_pend)
                begin
                    req.en      = !s_q.lock;
                    req.we      = 1'b1;
                    req.addr    = s_q.wr_addr;
                    req.wdata   = s_q.wr_data;
                    s_d.wr_pend = 1'b0;
                end
                else if (sock_rd)
                begin
                    req.en      = 1'b1;
                    req.addr    = pins.addr;
                    s_d.prd_iss = 1'b1;
                end
                else if (s_q.bus == B_MEM)
                begin
                    req.en      = 1'b1;
                    req.addr    = s_q.rom_addr[14:0];
                    s_d.bus_iss = 1'b1;
                end
            end
            default:
            begin
                s_d.phase = LD_READ;
            end
        endcase

        // A new pulse in the same cycle as service keeps its flag.
        if (!pins.pgm_n && s_q.pgm_n_d && !pins.ce_n)
        begin
            s_d.wr_pend = 1'b1;
        end

        // Decode once the last option byte arrives; held till reset.
        if (s_q.phase == LD_CAPTURE && s_q.ld_idx == OPT_LAST)
        begin
            s_d.opt.dual_clk = s_d.opt_bytes[0][OPT0_DUAL_BIT];
            s_d.opt.rst_out  = s_d.opt_bytes[0][OPT0_RSTO_BIT];
            s_d.opt.por      = s_d.opt_bytes[0][OPT0_POR_BIT];
            s_d.opt.port1_pullup_sel =
                ~s_d.opt_bytes[1][OPT1_PU_MSB:OPT1_PU_LSB];
            s_d.opt.port3_pullup_sel =
                ~s_d.opt_bytes[2][OPT2_PU_MSB:OPT2_PU_LSB];
        end

        // APB slave; registers other than ROM data answer one cycle into the access phase.
        unique case (s_q.bus)
            B_IDLE:
            begin
                if (bus_req)
                begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.pready = 1'b1;
                    unique case (paddr)
                        OFS_STATUS:
                        begin
                            s_d.prdata[STS_DONE_BIT] = s_q.done;
                            s_d.prdata[STS_DUAL_BIT] = s_q.opt.dual_clk;
                            s_d.prdata[STS_RSTO_BIT] = s_q.opt.rst_out;
                            s_d.prdata[STS_POR_BIT]  = s_q.opt.por;
                            s_d.prdata[STS_P1_LSB +: 4] =
                                s_q.opt.port1_pullup_sel;
                            s_d.prdata[STS_P3_LSB +: 6] =
                                s_q.opt.port3_pullup_sel;
                        end
                        OFS_OPT_LO: s_d.prdata = s_q.opt_bytes[3:0];
                        OFS_OPT_HI: s_d.prdata[23:0] = s_q.opt_bytes[6:4];
                        OFS_CTRL:
                        begin
                            s_d.prdata[CTRL_LOCK_BIT] = s_q.lock;
                            if (pwrite)
                            begin
                                s_d.lock = pwdata[CTRL_LOCK_BIT];
                            end
                        end
                        OFS_ROM_ADDR:
                        begin
                            s_d.prdata[15:0] = s_q.rom_addr;
                            if (pwrite)
                            begin
                                s_d.rom_addr = pwdata[15:0];
                            end
                        end
                        OFS_ROM_DATA:
                        begin
                            // Only the upper half of CPU space is ROM.
                            if (pwrite || !s_q.rom_addr[CPU_ROM_BIT])
                            begin
                                s_d.pslverr = 1'b1;
                            end
                            else
                            begin
                                s_d.pready = 1'b0;
                                s_d.bus    = B_MEM;
                            end
                        end
                        default: s_d.pslverr = 1'b1;
                    endcase
                end
            end
            // Wait for the arbiter to grant the array.
            B_MEM:
            begin
                if (s_q.bus_iss)
                begin
                    s_d.prdata = {24'h000000, mem_rd};
                    s_d.pready = 1'b1;
                    s_d.bus    = B_DONE;
                end
            end
            B_DONE: s_d.bus = B_IDLE;
            default: s_d.bus = B_IDLE;
        endcase
    end

    // Single state register for the whole core.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '{phase: LD_READ, bus: B_IDLE, pgm_n_d: 1'b1,
                     default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign prog_dout        = s_q.pdout;
    assign prog_doe         = s_q.pdoe;
    assign dual_clk_en      = s_q.opt.dual_clk;
    assign rst_out_en       = s_q.opt.rst_out;
    assign por_en           = s_q.opt.por;
    assign port1_pullup_sel = s_q.opt.port1_pullup_sel;
    assign port3_pullup_sel = s_q.opt.port3_pullup_sel;
    assign opt_valid        = s_q.done;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Socket traffic may own the array while the bus waits, so only
    // the cycle that really issues the bus read is held to the map.
    chk_rom_window_map: assert property (
        (s_q.bus == B_MEM && s_d.bus_iss) |->
            (req.addr == s_q.rom_addr[14:0] && s_q.rom_addr[CPU_ROM_BIT]))
        else $error("Bus read not mapped into ROM window.");
    chk_sock_reads_array: assert property (
        s_q.prd_iss |=> s_q.pdout == $past(mem_rd))
        else $error("Socket data not taken from the array.");
    chk_dual_clk_sel: assert property (
        s_q.done |-> dual_clk_en == s_q.opt_bytes[0][OPT0_DUAL_BIT])
        else $error("Clock select differs from option byte 0.");
    chk_reset_out_sel: assert property (
        s_q.done |-> rst_out_en == s_q.opt_bytes[0][OPT0_RSTO_BIT])
        else $error("Reset output differs from option byte 0.");
    chk_por_sel: assert property (
        s_q.done |-> por_en == s_q.opt_bytes[0][OPT0_POR_BIT])
        else $error("Power-on reset differs from option byte 0.");
    chk_port1_pullups: assert property (
        s_q.done |-> port1_pullup_sel == ~s_q.opt_bytes[1][7:4])
        else $error("Port 1 pull-ups not active-low decoded.");
    chk_port3_pullups: assert property (
        s_q.done |-> port3_pullup_sel == ~s_q.opt_bytes[2][7:2])
        else $error("Port 3 pull-ups not active-low decoded.");
    chk_options_held: assert property (
        (s_q.done && $past(s_q.done)) |->
            ($stable(dual_clk_en) && $stable(port3_pullup_sel)
             && $stable(por_en) && $stable(s_q.opt_bytes)))
        else $error("Option settings changed after load.");
    chk_load_time: assert property (
        $rose(presetn) |-> ##[13:15] opt_valid)
        else $error("Option load took the wrong number of cycles.");

    cov_load_done: cover property ($rose(opt_valid));
    cov_prog_write: cover property (req.en && req.we);
    cov_bus_rom_read: cover property (s_q.bus == B_DONE);
    cov_bus_error: cover property (pslverr);
endmodule // otpc_top

// File: dv/otpc_prog_model.sv
// Programmer-side model that drives the programming socket pins.
`timescale 1ns/10ps
module otpc_prog_model
(
    input  wire logic        pclk,  // System clock.
    output logic      [14:0] addr,  // Socket address.
    output logic      [7:0]  dq,    // Data driven while writing.
    output logic             ce_n,  // Chip enable.
    output logic             oe_n,  // Output enable.
    output logic             pgm_n, // Program strobe.
    input  wire logic [7:0]  dout,  // Device data out.
    input  wire logic        doe    // Device drives the data bus.
);
    // Strobes idle high so nothing is taken before a request.
    initial {addr, dq, ce_n, oe_n, pgm_n} = {15'h0, 8'h00, 3'h7};

    // Settle time around each strobe edge, above the sync delay.
    task automatic gap();
        repeat (5) @(posedge pclk);
    endtask

    // Options and program bytes use this same pulse.
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge pclk);
        addr <= a;
        dq   <= d;
        ce_n <= 1'b0;
        gap();
        pgm_n <= 1'b0;
        gap();
        pgm_n <= 1'b1;
        gap();
        ce_n <= 1'b1;
        dq   <= ~d;
        gap();
    endtask

    // Plain read of one byte; no signature mode is used.
    task automatic rd(input logic [14:0] a, output logic [7:0] d,
                      output logic e);
        @(posedge pclk);
        addr <= a;
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        repeat (7) @(posedge pclk);
        d = dout;
        e = doe;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        gap();
    endtask
endmodule // otpc_prog_model

// File: dv/otprom_option_config_tb.sv
// Self-checking bench for the PROM option loader and its socket.
`timescale 1ns/10ps
module otprom_option_config_tb;
    import otpc_pkg::*;
    // One APB read case: offset, mask, expected word, expected error.
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] m;
        logic [31:0] e;
        logic        er;
    } otpc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        prog_doe, prog_ce_n, prog_oe_n, prog_pgm_n, er;
    logic        dual_clk_en, rst_out_en, por_en, opt_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] prog_addr;
    logic [7:0]  prog_din, prog_dout, dq, b;
    logic [3:0]  port1_pullup_sel;
    logic [5:0]  port3_pullup_sel;
    logic [12:0] opts;
    int          err_total, check_count, cyc;
    otpc_row_t   rows [5];
    logic [15:0] ra [3] = '{16'h8007, 16'hFFFF, 16'h0007};
    logic [8:0]  rx [3] = '{9'h030, 9'h0A5, 9'h100};

    // The device owns the data wire while it drives it.
    assign prog_din = prog_doe ? prog_dout : dq;
    assign opts = {dual_clk_en, rst_out_en, por_en, port1_pullup_sel,
                   port3_pullup_sel};

    otpc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_din,
        .prog_dout, .prog_doe, .prog_ce_n, .prog_oe_n, .prog_pgm_n,
        .dual_clk_en, .rst_out_en, .por_en, .port1_pullup_sel,
        .port3_pullup_sel, .opt_valid);
    otpc_prog_model prog (.pclk(pclk), .addr(prog_addr), .dq(dq),
        .ce_n(prog_ce_n), .oe_n(prog_oe_n), .pgm_n(prog_pgm_n),
        .dout(prog_dout), .doe(prog_doe));

    // Free-running clock at 8 ns.
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Cuts a hang short; the whole run needs far fewer cycles.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            give_verdict();
        end
    end

    // Compares a result against its expected value.
    task automatic cmp(input logic [35:0] g, input logic [35:0] e);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // APB transfer: request held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Resets for 12 cycles, then waits for the option load.
    task automatic boot();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        cmp({opt_valid, opts}, 0);
        presetn <= 1'b1;
        repeat (18) @(posedge pclk);
        cmp(opt_valid, 1);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, check_count, cyc} = '0;
        rows[0] = {OFS_STATUS, 32'h3FFF, 32'h15A5, 1'b0};
        rows[1] = {OFS_OPT_LO, 32'hFFFFFFFF, 32'hFFAB5FEB, 1'b0};
        rows[2] = {OFS_OPT_HI, 32'h00FFFFFF, 32'h00FFFFFF, 1'b0};
        rows[3] = {12'h018, 32'h0, 32'h0, 1'b1};
        rows[4] = {OFS_CTRL, 32'h1, 32'h0, 1'b0};
        boot();
        cmp(opts, 13'h1C00);
        $display("test erased options done");
        prog.wr(15'h0000, 8'hEB);
        prog.wr(15'h0001, 8'h5F);
        prog.wr(15'h0002, 8'hAB);
        prog.wr(15'h0007, 8'h3C);
        prog.wr(15'h7FFF, 8'hA5);
        prog.wr(15'h0007, 8'hF0);
        cmp(opts, 13'h1C00);
        prog.rd(15'h0007, b, er);
        cmp({er, b}, 9'h130);
        $display("test socket programming done");
        boot();
        cmp(opts, 13'h0A95);
        // Ordinary register reads, including an unmapped offset.
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 0, rd, er);
            cmp({er, rd & rows[i].m}, {rows[i].er, rows[i].e});
        end
        $display("test register table done");
        // Window reads; bit 15 clear lies outside the ROM window.
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, OFS_ROM_ADDR, {16'h0, ra[i]}, rd, er);
            apb(1'b0, OFS_ROM_DATA, 0, rd, er);
            cmp({er, er ? 8'h00 : rd[7:0]}, rx[i]);
        end
        apb(1'b1, OFS_ROM_DATA, 0, rd, er);
        cmp(er, 1);
        // A locked socket must leave the array untouched.
        apb(1'b1, OFS_CTRL, 1, rd, er);
        prog.wr(15'h7FFF, 8'h00);
        apb(1'b1, OFS_ROM_ADDR, 32'hFFFF, rd, er);
        apb(1'b0, OFS_ROM_DATA, 0, rd, er);
        cmp({er, rd[7:0]}, 9'h0A5);
        $display("test window and lock done");
        give_verdict();
    end
endmodule // otprom_option_config_tb
